// ---- logic/lsd_pkg.sv ----
// Behaviour
// RULE_01 - In normal mode each serial clock rise shifts serial_in into a 16-stage chain whose last stage drives serial_out.
// RULE_02 - The strobe pulse that picks the next mode during the switching phase never loads the channel latch.
// RULE_03 - Error detection and gain programming are only available once special mode is entered.
// RULE_04 - In special mode a strobe captures the shifted code into the configuration latch, not the channel latch.
// RULE_05 - In special mode the stored error status is shifted out on serial_out by clocking the chain.
// RULE_06 - The controller holds blank_switch_detect_n low at least 2 us, 200 system clocks at 100 MHz, before status is valid.
// RULE_07 - Repeating the switching sequence from special mode returns the block to normal latching.
// RULE_08 - Channels are driven while blank_switch_detect_n is low and all blanked while it is high, in every phase.
// RULE_09 - A low pulse on blank_switch_detect_n exactly one serial clock wide enters the switching phase.
// RULE_10 - In special mode a low blank_switch_detect_n drives the channels and loads the error status into the chain.
// RULE_11 - In the switching phase the strobe level at the next serial clock rise selects special (high) or normal (low).
package lsd_pkg;
	localparam int CHAIN_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int SYS_CLK_MHZ = 100;
	localparam int ED_SETUP_NS = 2000;
	localparam int ED_SETUP_CYC = (ED_SETUP_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int ED_CNT_W = 8;
	localparam logic [ED_CNT_W-1:0] ED_CNT_DONE = ED_CNT_W'(ED_SETUP_CYC);
	localparam logic [ED_CNT_W-1:0] ED_CNT_LOAD = ED_CNT_W'(ED_SETUP_CYC - 1);
	localparam logic [1:0] SW_EDGES_ONE = 2'h1;
	localparam logic [1:0] SW_EDGES_MAX = 2'h3;
	localparam logic [CHAIN_W-1:0] CHAIN_RST = 16'h0000;
	localparam logic [CHAIN_W-1:0] LATCH_RST = 16'h0000;
	localparam logic [CHAIN_W-1:0] GAIN_RST = 16'h0000;
	localparam logic [CHAIN_W-1:0] FAULT_RST = 16'hFFFF;

	typedef enum logic [1:0] {
		LSD_PH_NORMAL,
		LSD_PH_SWITCH,
		LSD_PH_SPECIAL
	} lsd_phase_t;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic strobe;
		logic blank_n;
	} lsd_pins_t;

	localparam lsd_pins_t PINS_RST = 4'h1;

	typedef struct packed {
		logic                is_config;
		logic [CHAIN_W-1:0]  data;
	} lsd_capture_t;

	localparam int CAP_W = $bits(lsd_capture_t);

	function automatic logic lsd_rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	function automatic logic lsd_fall(input logic cur, input logic prev);
		return prev & ~cur;
	endfunction
endpackage

// ---- logic/lsd_serial_ctrl.sv ----
`timescale 1ns/1ps
module lsd_fifo #(
	parameter int WIDTH = lsd_pkg::CAP_W,
	parameter int DEPTH = lsd_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_n,
	// fill side
	input  wire logic              i_wr_valid,
	output logic                   o_wr_ready,
	input  wire logic [WIDTH-1:0]  i_wr_data,
	// drain side
	output logic                   o_rd_valid,
	input  wire logic              i_rd_ready,
	output logic [WIDTH-1:0]       o_rd_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]  mem_q [DEPTH];
	logic [AW:0]       wr_q;
	logic [AW:0]       wr_d;
	logic [AW:0]       rd_q;
	logic [AW:0]       rd_d;
	logic              wr_fire;
	logic              rd_fire;

	// full when pointers differ only in the wrap bit
	assign o_wr_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign o_rd_valid = (wr_q != rd_q);
	assign o_rd_data  = mem_q[rd_q[AW-1:0]];

	always_comb begin
		wr_fire = i_wr_valid && o_wr_ready;
		rd_fire = o_rd_valid && i_rd_ready;
		wr_d    = wr_q + {{AW{1'b0}}, wr_fire};
		rd_d    = rd_q + {{AW{1'b0}}, rd_fire};
	end

	always_ff @(posedge i_sys_clk) begin
		if (wr_fire) begin
			mem_q[wr_q[AW-1:0]] <= i_wr_data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end
endmodule // lsd_fifo

module lsd_serial_ctrl (
	// clock and reset
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst_n,
	// serial pins
	input  wire logic                         i_serial_clk,
	input  wire logic                         i_serial_in,
	input  wire logic                         i_latch_mode_config_strobe,
	input  wire logic                         i_blank_switch_detect_n,
	output logic                              o_serial_out,
	// channel side
	input  wire logic [lsd_pkg::CHAIN_W-1:0]  i_channel_fault_n,
	output logic [lsd_pkg::CHAIN_W-1:0]       o_sink_channels,
	output logic [lsd_pkg::CHAIN_W-1:0]       o_gain_code,
	output logic                              o_special_mode,
	// capture buffer
	output logic                              o_capture_ready,
	input  wire logic                         i_apply_ready
);
	lsd_pkg::lsd_pins_t             pins_in;
	lsd_pkg::lsd_pins_t             s1_q;
	lsd_pkg::lsd_pins_t             s2_q;
	lsd_pkg::lsd_pins_t             prev_q;
	logic [lsd_pkg::CHAIN_W-1:0]    fault_s1_q;
	logic [lsd_pkg::CHAIN_W-1:0]    fault_s2_q;

	lsd_pkg::lsd_phase_t            phase_q;
	lsd_pkg::lsd_phase_t            phase_d;
	logic [1:0]                     sw_cnt_q;
	logic [1:0]                     sw_cnt_d;
	logic [lsd_pkg::ED_CNT_W-1:0]   ed_cnt_q;
	logic [lsd_pkg::ED_CNT_W-1:0]   ed_cnt_d;
	logic [lsd_pkg::CHAIN_W-1:0]    chain_q;
	logic [lsd_pkg::CHAIN_W-1:0]    chain_d;
	logic [lsd_pkg::CHAIN_W-1:0]    latch_q;
	logic [lsd_pkg::CHAIN_W-1:0]    latch_d;
	logic [lsd_pkg::CHAIN_W-1:0]    gain_q;
	logic [lsd_pkg::CHAIN_W-1:0]    gain_d;
	logic [lsd_pkg::CHAIN_W-1:0]    sink_q;
	logic [lsd_pkg::CHAIN_W-1:0]    sink_d;

	logic                           shift;
	logic                           strobe_rise;
	logic                           blank_fall;
	logic                           blank_rise;
	logic                           sw_fire;
	logic                           err_load;
	logic                           push;
	lsd_pkg::lsd_capture_t          push_word;
	logic                           fifo_ready;
	logic                           pop_valid;
	lsd_pkg::lsd_capture_t          pop_word;
	logic                           apply;

	// pin synchronisers
	assign pins_in = {i_serial_clk, i_serial_in, i_latch_mode_config_strobe, i_blank_switch_detect_n};

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q       <= lsd_pkg::PINS_RST;
			s2_q       <= lsd_pkg::PINS_RST;
			prev_q     <= lsd_pkg::PINS_RST;
			fault_s1_q <= lsd_pkg::FAULT_RST;
			fault_s2_q <= lsd_pkg::FAULT_RST;
		end else begin
			s1_q       <= pins_in;
			s2_q       <= s1_q;
			prev_q     <= s2_q;
			fault_s1_q <= i_channel_fault_n;
			fault_s2_q <= fault_s1_q;
		end
	end

	// edge events
	always_comb begin
		shift       = lsd_pkg::lsd_rise(s2_q.sclk, prev_q.sclk);
		strobe_rise = lsd_pkg::lsd_rise(s2_q.strobe, prev_q.strobe);
		blank_fall  = lsd_pkg::lsd_fall(s2_q.blank_n, prev_q.blank_n);
		blank_rise  = lsd_pkg::lsd_rise(s2_q.blank_n, prev_q.blank_n);
	end

	// control next state
	always_comb begin
		sw_cnt_d = sw_cnt_q;
		if (blank_fall) begin
			sw_cnt_d = {1'b0, shift};
		end else if (!s2_q.blank_n && shift && sw_cnt_q != lsd_pkg::SW_EDGES_MAX) begin
			sw_cnt_d = sw_cnt_q + 2'h1;
		end
		// RULE_09 one clock low pulse
		sw_fire = blank_rise && (sw_cnt_q == lsd_pkg::SW_EDGES_ONE);
		phase_d = phase_q;
		// RULE_07 repeat switch sequence
		if (sw_fire) begin
			phase_d = lsd_pkg::LSD_PH_SWITCH;
		end else begin
			unique case (phase_q)
				lsd_pkg::LSD_PH_NORMAL: begin
					phase_d = lsd_pkg::LSD_PH_NORMAL;
				end
				// RULE_11 strobe level selects
				lsd_pkg::LSD_PH_SWITCH: begin
					if (shift) begin
						phase_d = s2_q.strobe ? lsd_pkg::LSD_PH_SPECIAL : lsd_pkg::LSD_PH_NORMAL;
					end
				end
				lsd_pkg::LSD_PH_SPECIAL: begin
					phase_d = lsd_pkg::LSD_PH_SPECIAL;
				end
				default: begin
					phase_d = lsd_pkg::LSD_PH_NORMAL;
				end
			endcase
		end
		// RULE_03 detect only in special
		ed_cnt_d = ed_cnt_q;
		if (phase_q != lsd_pkg::LSD_PH_SPECIAL || s2_q.blank_n) begin
			ed_cnt_d = '0;
		end else if (ed_cnt_q != lsd_pkg::ED_CNT_DONE) begin
			ed_cnt_d = ed_cnt_q + {{(lsd_pkg::ED_CNT_W-1){1'b0}}, 1'b1};
		end
		// RULE_10 detect loads status
		err_load = (phase_q == lsd_pkg::LSD_PH_SPECIAL) && !s2_q.blank_n && (ed_cnt_q == lsd_pkg::ED_CNT_LOAD);
		// RULE_01 serial shift chain
		if (err_load) begin
			chain_d = fault_s2_q;
		end else if (shift) begin
			chain_d = {chain_q[lsd_pkg::CHAIN_W-2:0], s2_q.sdata};
		end else begin
			chain_d = chain_q;
		end
		// RULE_02 no latch while switching
		unique case (phase_q)
			lsd_pkg::LSD_PH_NORMAL: begin
				push = s2_q.strobe && (strobe_rise || shift);
			end
			lsd_pkg::LSD_PH_SPECIAL: begin
				push = strobe_rise;
			end
			default: begin
				push = 1'b0;
			end
		endcase
		// RULE_04 special strobe targets config
		push_word.is_config = (phase_q == lsd_pkg::LSD_PH_SPECIAL);
		push_word.data      = chain_d;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_q  <= lsd_pkg::LSD_PH_NORMAL;
			sw_cnt_q <= '0;
			ed_cnt_q <= '0;
			chain_q  <= lsd_pkg::CHAIN_RST;
		end else begin
			phase_q  <= phase_d;
			sw_cnt_q <= sw_cnt_d;
			ed_cnt_q <= ed_cnt_d;
			chain_q  <= chain_d;
		end
	end

	// capture buffer between strobe and latches
	lsd_fifo #(
		.WIDTH (lsd_pkg::CAP_W),
		.DEPTH (lsd_pkg::FIFO_DEPTH)
	) u_capture_fifo (
		.i_sys_clk  (i_sys_clk),
		.i_rst_n    (i_rst_n),
		.i_wr_valid (push),
		.o_wr_ready (fifo_ready),
		.i_wr_data  (push_word),
		.o_rd_valid (pop_valid),
		.i_rd_ready (i_apply_ready),
		.o_rd_data  (pop_word)
	);

	// latch and output next state
	always_comb begin
		apply   = pop_valid && i_apply_ready;
		latch_d = latch_q;
		gain_d  = gain_q;
		if (apply && pop_word.is_config) begin
			gain_d = pop_word.data;
		end else if (apply) begin
			latch_d = pop_word.data;
		end
		// RULE_08 enable or blank channels
		sink_d = latch_d & {lsd_pkg::CHAIN_W{~s2_q.blank_n}};
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			latch_q <= lsd_pkg::LATCH_RST;
			gain_q  <= lsd_pkg::GAIN_RST;
			sink_q  <= '0;
		end else begin
			latch_q <= latch_d;
			gain_q  <= gain_d;
			sink_q  <= sink_d;
		end
	end

	// RULE_05 status leaves on serial out
	assign o_serial_out    = chain_q[lsd_pkg::CHAIN_W-1];
	assign o_sink_channels = sink_q;
	assign o_gain_code     = gain_q;
	assign o_special_mode  = (phase_q == lsd_pkg::LSD_PH_SPECIAL);
	assign o_capture_ready = fifo_ready;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_one_clk_low;
		blank_rise && (sw_cnt_q == lsd_pkg::SW_EDGES_ONE);
	endsequence

	sequence s_switch_sample;
		(phase_q == lsd_pkg::LSD_PH_SWITCH) && shift && !sw_fire;
	endsequence

	// RULE_01 check shift
	a_chain_shift: assert property (shift && !err_load |=> //RULE_01
		chain_q == {$past(chain_q[lsd_pkg::CHAIN_W-2:0]), $past(s2_q.sdata)})
		else $error("chain did not shift serial input");

	// RULE_02 check switch phase
	a_switch_no_latch: assert property ((phase_q == lsd_pkg::LSD_PH_SWITCH) |-> !push) //RULE_02
		else $error("strobe captured during switching phase");

	// RULE_03 check special only
	a_special_only: assert property ((phase_q != lsd_pkg::LSD_PH_SPECIAL) |-> //RULE_03
		!err_load && !(push && push_word.is_config))
		else $error("special feature used outside special mode");

	// RULE_04 check config capture
	a_config_capture: assert property ((phase_q == lsd_pkg::LSD_PH_SPECIAL) && strobe_rise |-> //RULE_04
		push && push_word.is_config && push_word.data == chain_d)
		else $error("special strobe not routed to configuration");

	// RULE_05 check status readout
	a_status_readout: assert property (err_load |=> o_serial_out == $past(fault_s2_q[lsd_pkg::CHAIN_W-1])) //RULE_05
		else $error("error status not on serial output");

	// RULE_08 check drive and blank
	a_channels_blank: assert property (s2_q.blank_n |=> o_sink_channels == '0) //RULE_08
		else $error("channels driven while blanked");
	a_channels_drive: assert property (!s2_q.blank_n |=> o_sink_channels == latch_q) //RULE_08
		else $error("channels not driven while enabled");

	// RULE_09 check switch entry
	a_switch_entry: assert property (s_one_clk_low |=> phase_q == lsd_pkg::LSD_PH_SWITCH) //RULE_09
		else $error("one clock pulse did not start switching");

	// RULE_10 check detect load
	a_detect_load: assert property ((phase_q == lsd_pkg::LSD_PH_SPECIAL) && !s2_q.blank_n && //RULE_10
		(ed_cnt_q == lsd_pkg::ED_CNT_LOAD) |=> chain_q == $past(fault_s2_q))
		else $error("error status not loaded after detect time");

	// RULE_11 check mode select
	a_mode_select: assert property (s_switch_sample |=> //RULE_11
		phase_q == ($past(s2_q.strobe) ? lsd_pkg::LSD_PH_SPECIAL : lsd_pkg::LSD_PH_NORMAL))
		else $error("switching phase chose wrong mode");
endmodule // lsd_serial_ctrl

// ---- dv/lsd_ctrl_model.sv ----
`timescale 1ns/1ps
module lsd_ctrl_model (
	// clock
	input  wire logic  i_sys_clk,
	// controller pins
	output logic       o_sclk,
	output logic       o_sdata,
	output logic       o_strobe,
	output logic       o_blank_n,
	// cascade return
	input  wire logic  i_serial_out
);
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
		o_strobe = 1'b0;
		o_blank_n = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic clk_pulse();
		o_sclk = 1'b1;
		wt(4);
		o_sclk = 1'b0;
		wt(4);
	endtask

	task automatic set_lines(input logic s, input logic b);
		o_strobe = s;
		o_blank_n = b;
		wt(4);
	endtask

	task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
		for (int i = 15; i >= 0; i--) begin
			o_sdata = din[i];
			wt(4);
			dout[i] = i_serial_out;
			clk_pulse();
		end
		o_sdata = ~din[0];
	endtask

	// one-clock switch pulse then mode pick
	task automatic switch_mode(input logic sel);
		set_lines(1'b0, 1'b0);
		clk_pulse();
		set_lines(1'b0, 1'b1);
		set_lines(sel, 1'b1);
		clk_pulse();
		set_lines(1'b0, 1'b1);
	endtask

	task automatic hold_detect(input int n);
		o_blank_n = 1'b0;
		wt(n);
	endtask
endmodule // lsd_ctrl_model

// ---- dv/lsd_serial_ctrl_test.sv ----
`timescale 1ns/1ps
module lsd_serial_ctrl_test;
	logic         sys_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         sclk;
	logic         sdata;
	logic         strobe;
	logic         blank_n;
	logic         serial_out;
	logic [15:0]  fault_n;
	logic [15:0]  sink;
	logic [15:0]  gain;
	logic         special;
	logic         cap_ready;
	logic         apply_ready;
	int           bad_count = 0;
	int           num_checks = 0;
	int           cyc = 0;
	logic [15:0]  d;

	always #5 sys_clk = ~sys_clk;

	lsd_serial_ctrl DUT (
		.i_sys_clk                  (sys_clk),
		.i_rst_n                    (rst_n),
		.i_serial_clk               (sclk),
		.i_serial_in                (sdata),
		.i_latch_mode_config_strobe (strobe),
		.i_blank_switch_detect_n    (blank_n),
		.o_serial_out               (serial_out),
		.i_channel_fault_n          (fault_n),
		.o_sink_channels            (sink),
		.o_gain_code                (gain),
		.o_special_mode             (special),
		.o_capture_ready            (cap_ready),
		.i_apply_ready              (apply_ready)
	);

	lsd_ctrl_model ctrl (
		.i_sys_clk    (sys_clk),
		.o_sclk       (sclk),
		.o_sdata      (sdata),
		.o_strobe     (strobe),
		.o_blank_n    (blank_n),
		.i_serial_out (serial_out)
	);

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic see_sink(input logic [15:0] exp);
		ctrl.set_lines(1'b0, 1'b0);
		ctrl.wt(4);
		chk("sink driven", exp, sink);
		ctrl.set_lines(1'b0, 1'b1);
		ctrl.wt(4);
		chk("sink blanked", 16'h0000, sink);
	endtask

	task automatic t_shift_latch();
		ctrl.xfer(16'hA5C3, d);
		ctrl.xfer(16'h1E87, d);
		chk("cascade out", 16'hA5C3, d);
		ctrl.set_lines(1'b1, 1'b1);
		ctrl.set_lines(1'b0, 1'b1);
		ctrl.wt(8);
		see_sink(16'h1E87);
	endtask

	task automatic t_to_special();
		ctrl.switch_mode(1'b1);
		ctrl.wt(4);
		chk("special mode", 16'h0001, {15'h0000, special});
		chk("gain after switch", 16'h0000, gain);
		see_sink(16'h1E87);
	endtask

	task automatic t_config();
		ctrl.xfer(16'h3C5A, d);
		ctrl.set_lines(1'b1, 1'b1);
		ctrl.set_lines(1'b0, 1'b1);
		ctrl.wt(8);
		chk("gain code", 16'h3C5A, gain);
		see_sink(16'h1E87);
	endtask

	task automatic t_detect(input logic [15:0] pat);
		fault_n = pat;
		ctrl.hold_detect(210);
		chk("sink in detect", 16'h1E87, sink);
		ctrl.set_lines(1'b0, 1'b1);
		ctrl.xfer(16'h0000, d);
		chk("error status", pat, d);
	endtask

	task automatic t_to_normal();
		ctrl.switch_mode(1'b0);
		ctrl.wt(4);
		chk("normal mode", 16'h0000, {15'h0000, special});
		ctrl.xfer(16'h6D29, d);
		ctrl.set_lines(1'b1, 1'b1);
		ctrl.set_lines(1'b0, 1'b1);
		ctrl.wt(8);
		see_sink(16'h6D29);
		chk("gain kept in normal", 16'h3C5A, gain);
	endtask

	task automatic t_fill();
		apply_ready = 1'b0;
		ctrl.set_lines(1'b1, 1'b1);
		ctrl.xfer(16'h0F0F, d);
		chk("buffer full", 16'h0000, {15'h0000, cap_ready});
		ctrl.set_lines(1'b0, 1'b1);
		apply_ready = 1'b1;
		ctrl.wt(40);
		chk("buffer drained", 16'h0001, {15'h0000, cap_ready});
		see_sink(16'h8787);
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		fault_n = 16'hFFFF;
		apply_ready = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		ctrl.wt(4);
		t_shift_latch();
		t_to_special();
		t_config();
		t_detect(16'hF7B1);
		t_detect(16'h084E);
		t_to_normal();
		t_fill();
		end_of_test();
	end
endmodule // lsd_serial_ctrl_test
